// ---- include/sdwp_consts.svh ----
// Constants for the SDRAM write and precharge block
`ifndef SDWP_CONSTS_SVH
`define SDWP_CONSTS_SVH

// Register offsets on the plain register port
`define SDWP_REG_MODE 4'h0
`define SDWP_REG_STATUS 4'h4
`define SDWP_REG_WCOUNT 4'h8

// Mode register fields and reset value
`define SDWP_MODE_RST 10'h023
`define SDWP_MODE_MASK 10'h277
`define SDWP_BL_MSB 2
`define SDWP_BL_LSB 0
`define SDWP_CL_MSB 6
`define SDWP_CL_LSB 4
`define SDWP_WBM_BIT 9
`define SDWP_BL_CONT 3'h7

// Status register fields
`define SDWP_ST_WR_BIT 8
`define SDWP_ST_RD_BIT 9

// Address pin fields
`define SDWP_SCOPE_BIT 10
`define SDWP_COL_MSB 7

// Timing in ns and derived clock counts (least times round up, min 1)
`define SDWP_CLK_NS 50
`define SDWP_TWR_NS 15
`define SDWP_TRP_NS 20
`define SDWP_WR_RAW ((`SDWP_TWR_NS + `SDWP_CLK_NS - 1) / `SDWP_CLK_NS)
`define SDWP_WR_CYC ((`SDWP_WR_RAW < 1) ? 1 : `SDWP_WR_RAW)
`define SDWP_RP_RAW ((`SDWP_TRP_NS + `SDWP_CLK_NS - 1) / `SDWP_CLK_NS)
`define SDWP_TRP_CYC ((`SDWP_RP_RAW < 1) ? 1 : `SDWP_RP_RAW)

`endif

// ---- include/sdwp_pkg.sv ----
// Types shared by the SDRAM write and precharge block
package sdwp_pkg;
  // Data word on the DQ pins
  typedef logic [15:0] sdwp_word_t;
  // Per-bank state
  typedef enum logic [1:0] {BANK_IDLE, BANK_ACTIVE, BANK_PRECH} sdwp_bank_st_t;
  // Decoded command
  typedef enum logic [2:0] {
    CMD_NOP, CMD_ACT, CMD_READ, CMD_WRITE, CMD_PRE, CMD_BST, CMD_OTHER
  } sdwp_cmd_t;
endpackage

// ---- rtl/sdwp_bank.sv ----
// One bank: idle, active or precharging, with pending auto precharge
`timescale 1ns/1ns
`default_nettype none
`include "sdwp_consts.svh"
module sdwp_bank (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Bank requests
  input wire logic activate_i,
  input wire logic precharge_i,
  input wire logic schedule_i,
  // Bank state
  output sdwp_pkg::sdwp_bank_st_t state_o
);
  import sdwp_pkg::*;

  sdwp_bank_st_t st_ff, nxt_st; // Bank state
  logic pend_ff, nxt_pend; // Auto precharge waiting on recovery
  logic [3:0] cnt_ff, nxt_cnt; // Recovery or precharge countdown

  // Next state of the bank
  always_comb begin
    nxt_st = st_ff;
    nxt_pend = pend_ff;
    nxt_cnt = cnt_ff;
    case (st_ff)
      BANK_IDLE: begin
        if (activate_i) begin
          nxt_st = BANK_ACTIVE;
        end
      end
      BANK_ACTIVE: begin
        // explicit precharge wins over pending one
        if (precharge_i) begin
          nxt_st = BANK_PRECH;
          nxt_pend = 1'b0;
          nxt_cnt = 4'(`SDWP_TRP_CYC);
        end else if (schedule_i) begin
          // recovery of at least one clock
          nxt_pend = 1'b1;
          nxt_cnt = 4'(`SDWP_WR_CYC);
        end else if (pend_ff) begin
          if (cnt_ff == 4'h1) begin
            nxt_st = BANK_PRECH;
            nxt_pend = 1'b0;
            nxt_cnt = 4'(`SDWP_TRP_CYC);
          end else begin
            nxt_cnt = cnt_ff - 4'h1;
          end
        end
      end
      BANK_PRECH: begin
        if (cnt_ff == 4'h1) begin
          nxt_st = BANK_IDLE;
        end else begin
          nxt_cnt = cnt_ff - 4'h1;
        end
      end
      default: begin
        nxt_st = BANK_IDLE;
      end
    endcase
  end

  // Register the bank state
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_ff <= BANK_IDLE;
      pend_ff <= 1'b0;
      cnt_ff <= 4'h0;
    end else begin
      st_ff <= nxt_st;
      pend_ff <= nxt_pend;
      cnt_ff <= nxt_cnt;
    end
  end

  assign state_o = st_ff;

  // Auto precharge never starts on the scheduling edge
  property p_recovery;
    @(posedge clk_i) disable iff (!rst_n_i)
    (st_ff == BANK_ACTIVE && schedule_i && !precharge_i)
      |=> (st_ff == BANK_ACTIVE && pend_ff);
  endproperty
  a_recovery: assert property (p_recovery)
    else $error("auto precharge started without recovery");

  // Pending precharge fires when the countdown ends
  property p_pend_fire;
    @(posedge clk_i) disable iff (!rst_n_i)
    (st_ff == BANK_ACTIVE && pend_ff && cnt_ff == 4'h1 && !precharge_i)
      |=> (st_ff == BANK_PRECH && !pend_ff);
  endproperty
  a_pend_fire: assert property (p_pend_fire)
    else $error("pending precharge did not start");
endmodule
`default_nettype wire

// ---- rtl/sdwp_top.sv ----
// SDRAM write burst, data mask and precharge logic with register port
// Function
// - First data captured with WRITE edge
// - After burst, ignore data, stay high-Z
// - Continuous page wraps to column zero
// - New WRITE truncates, data is new
// - READ truncates write, data ignored
// - Auto precharge recovery at least one clock
// - Burst terminate edge data is ignored
// - Single-write mode writes one column
// - Scope bit high closes all banks
// - Precharged bank idle until activated
// - Scope bit with access selects auto precharge
// - Continuous length overrides single-write, no auto
// - READ cuts auto-precharging read, precharge starts
// - WRITE cuts auto-precharging read, precharge starts
// - READ cuts auto write, recovery then precharge
// - WRITE cuts auto write, recovery then precharge
`timescale 1ns/1ns
`default_nettype none
`include "sdwp_consts.svh"
module sdwp_top (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Command and address pins
  input wire logic cs_n_i,
  input wire logic ras_n_i,
  input wire logic cas_n_i,
  input wire logic we_n_i,
  input wire logic [11:0] addr_i,
  input wire logic bank_select_low_i,
  input wire logic bank_select_high_i,
  // Data pins
  input wire logic dqm_i,
  input wire sdwp_pkg::sdwp_word_t dq_i,
  output sdwp_pkg::sdwp_word_t dq_o,
  output logic dq_oe_o,
  // Register port
  input wire logic [3:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [31:0] reg_rdata_o,
  // Write burst in progress
  output logic wr_busy_o
);
  import sdwp_pkg::*;

  // Burst length from the mode code, continuous gives a full page
  function automatic logic [8:0] bl_len(input logic [2:0] code);
    case (code)
      3'h0: bl_len = 9'h001;
      3'h1: bl_len = 9'h002;
      3'h2: bl_len = 9'h004;
      3'h3: bl_len = 9'h008;
      default: bl_len = 9'h100;
    endcase
  endfunction

  // Next column, wrapping inside the burst block or the page
  function automatic logic [7:0] nxt_col(input logic [7:0] col,
                                         input logic [8:0] len);
    logic [7:0] m;
    m = 8'(len - 9'h001);
    nxt_col = (col & ~m) | ((col + 8'h01) & m);
  endfunction

  logic [9:0] mode_ff, nxt_mode; // Mode register
  logic [31:0] rdata_ff, nxt_rdata; // Read data of the register port
  logic [15:0] wcnt_ff, nxt_wcnt; // Count of written elements
  logic wr_act_ff, nxt_wr_act; // Write burst running
  logic [1:0] wr_bank_ff, nxt_wr_bank; // Bank of the write burst
  logic [7:0] wr_col_ff, nxt_wr_col; // Column for the next element
  logic [8:0] wr_left_ff, nxt_wr_left; // Elements still to come
  logic [8:0] wr_len_ff, nxt_wr_len; // Length of the write burst
  logic wr_ap_ff, nxt_wr_ap; // Write burst has auto precharge
  logic wr_cont_ff, nxt_wr_cont; // Write burst is continuous
  logic rd_act_ff, nxt_rd_act; // Read burst running
  logic [1:0] rd_bank_ff, nxt_rd_bank; // Bank of the read burst
  logic [8:0] rd_left_ff, nxt_rd_left; // Read elements still to come
  logic rd_ap_ff, nxt_rd_ap; // Read burst has auto precharge
  sdwp_word_t mem [1024]; // Array contents, four banks of one page
  logic mem_we; // Store one element this edge
  logic [9:0] mem_addr; // Bank and column of the store
  logic [3:0] bk_act, bk_pre, bk_sched; // Per-bank requests
  sdwp_bank_st_t bk_st [4]; // Per-bank state
  sdwp_cmd_t cmd; // Decoded command
  logic [1:0] ba; // Selected bank
  logic [7:0] col; // Selected column
  logic scope; // Precharge scope or auto precharge bit
  logic cont; // Continuous page mode programmed
  logic wr_go, rd_go; // Access accepted this edge
  logic [8:0] len; // Programmed burst length

  // Pin decode
  always_comb begin
    case ({cs_n_i, ras_n_i, cas_n_i, we_n_i})
      4'b0011: cmd = CMD_ACT;
      4'b0101: cmd = CMD_READ;
      4'b0100: cmd = CMD_WRITE;
      4'b0010: cmd = CMD_PRE;
      4'b0110: cmd = CMD_BST;
      4'b0111: cmd = CMD_NOP;
      default: cmd = cs_n_i ? CMD_NOP : CMD_OTHER;
    endcase
  end
  assign ba = {bank_select_high_i, bank_select_low_i};
  assign col = addr_i[`SDWP_COL_MSB:0];
  assign scope = addr_i[`SDWP_SCOPE_BIT];
  assign cont = (mode_ff[`SDWP_BL_MSB:`SDWP_BL_LSB] == `SDWP_BL_CONT);
  assign len = bl_len(mode_ff[`SDWP_BL_MSB:`SDWP_BL_LSB]);
  // access only to an active bank
  assign wr_go = (cmd == CMD_WRITE) && (bk_st[ba] == BANK_ACTIVE);
  assign rd_go = (cmd == CMD_READ) && (bk_st[ba] == BANK_ACTIVE);

  // Burst engine: next burst state, array stores and bank requests
  always_comb begin
    nxt_wr_act = wr_act_ff;
    nxt_wr_bank = wr_bank_ff;
    nxt_wr_col = wr_col_ff;
    nxt_wr_left = wr_left_ff;
    nxt_wr_len = wr_len_ff;
    nxt_wr_ap = wr_ap_ff;
    nxt_wr_cont = wr_cont_ff;
    nxt_rd_act = rd_act_ff;
    nxt_rd_bank = rd_bank_ff;
    nxt_rd_left = rd_left_ff;
    nxt_rd_ap = rd_ap_ff;
    mem_we = 1'b0;
    mem_addr = {wr_bank_ff, wr_col_ff};
    bk_act = 4'h0;
    bk_pre = 4'h0;
    bk_sched = 4'h0;
    // Running bursts advance only on NOP, ACTIVE and other edges, not on PRECHARGE or column commands
    if (cmd == CMD_NOP || cmd == CMD_ACT || cmd == CMD_OTHER) begin
      if (wr_act_ff) begin
        mem_we = !dqm_i;
        nxt_wr_col = nxt_col(wr_col_ff, wr_len_ff);
        if (!wr_cont_ff) begin
          nxt_wr_left = wr_left_ff - 9'h001;
          if (wr_left_ff == 9'h001) begin
            nxt_wr_act = 1'b0;
            bk_sched[wr_bank_ff] = wr_ap_ff;
          end
        end
      end
      if (rd_act_ff && !(cont && !rd_ap_ff && rd_left_ff == 9'h0)) begin
        nxt_rd_left = rd_left_ff - 9'h001;
        if (rd_left_ff == 9'h001) begin
          nxt_rd_act = 1'b0;
          // read auto precharge at end of burst
          bk_pre[rd_bank_ff] = rd_ap_ff;
        end
      end
    end
    case (cmd)
      CMD_ACT: begin
        bk_act[ba] = 1'b1;
      end
      CMD_WRITE: begin
        if (wr_go) begin
          // old auto write recovers from this edge
          if (wr_act_ff && wr_ap_ff && wr_bank_ff != ba) begin
            bk_sched[wr_bank_ff] = 1'b1;
          end
          if (rd_act_ff && rd_ap_ff && rd_bank_ff != ba) begin
            bk_pre[rd_bank_ff] = 1'b1;
          end
          nxt_rd_act = 1'b0;
          // first element stored on the command edge
          mem_we = !dqm_i;
          mem_addr = {ba, col};
          nxt_wr_bank = ba;
          nxt_wr_cont = cont;
          nxt_wr_len = (mode_ff[`SDWP_WBM_BIT] && !cont) ? 9'h001 : len;
          nxt_wr_col = nxt_col(col, nxt_wr_len);
          nxt_wr_left = nxt_wr_len - 9'h001;
          // auto precharge per command, never continuous
          nxt_wr_ap = scope && !cont;
          nxt_wr_act = cont || (nxt_wr_len != 9'h001);
          if (!nxt_wr_act) begin
            bk_sched[ba] = nxt_wr_ap;
          end
        end
      end
      CMD_READ: begin
        if (rd_go) begin
          // auto write recovers counted from the READ
          if (wr_act_ff && wr_ap_ff && wr_bank_ff != ba) begin
            bk_sched[wr_bank_ff] = 1'b1;
          end
          // write burst stops, no data taken
          nxt_wr_act = 1'b0;
          if (rd_act_ff && rd_ap_ff && rd_bank_ff != ba) begin
            bk_pre[rd_bank_ff] = 1'b1;
          end
          nxt_rd_act = 1'b1;
          nxt_rd_bank = ba;
          nxt_rd_left = cont ? 9'h0 : len;
          nxt_rd_ap = scope && !cont;
          if (!cont && len == 9'h001) begin
            nxt_rd_act = 1'b0;
            bk_pre[ba] = nxt_rd_ap;
          end
        end
      end
      CMD_BST: begin
        // data on the terminate edge is dropped
        nxt_wr_act = 1'b0;
        nxt_rd_act = 1'b0;
      end
      CMD_PRE: begin
        // scope bit selects all banks or one
        if (scope) begin
          bk_pre = 4'hF;
          nxt_wr_act = 1'b0;
          nxt_rd_act = 1'b0;
        end else begin
          bk_pre[ba] = 1'b1;
          if (wr_bank_ff == ba) begin
            nxt_wr_act = 1'b0;
          end
          if (rd_bank_ff == ba) begin
            nxt_rd_act = 1'b0;
          end
        end
      end
      default: begin
        bk_act = 4'h0;
      end
    endcase
  end

  // Register the burst engine
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_act_ff <= 1'b0;
      wr_bank_ff <= 2'h0;
      wr_col_ff <= 8'h00;
      wr_left_ff <= 9'h000;
      wr_len_ff <= 9'h001;
      wr_ap_ff <= 1'b0;
      wr_cont_ff <= 1'b0;
      rd_act_ff <= 1'b0;
      rd_bank_ff <= 2'h0;
      rd_left_ff <= 9'h000;
      rd_ap_ff <= 1'b0;
    end else begin
      wr_act_ff <= nxt_wr_act;
      wr_bank_ff <= nxt_wr_bank;
      wr_col_ff <= nxt_wr_col;
      wr_left_ff <= nxt_wr_left;
      wr_len_ff <= nxt_wr_len;
      wr_ap_ff <= nxt_wr_ap;
      wr_cont_ff <= nxt_wr_cont;
      rd_act_ff <= nxt_rd_act;
      rd_bank_ff <= nxt_rd_bank;
      rd_left_ff <= nxt_rd_left;
      rd_ap_ff <= nxt_rd_ap;
    end
  end

  // Array store, no reset on contents
  always_ff @(posedge clk_i) begin
    if (mem_we) begin
      mem[mem_addr] <= dq_i;
    end
  end

  for (genvar g = 0; g < 4; g++) begin : g_bank
    sdwp_bank u_bank (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .activate_i(bk_act[g]),
      .precharge_i(bk_pre[g]),
      .schedule_i(bk_sched[g]),
      .state_o(bk_st[g])
    );
  end

  // Register port: mode write, status and count reads
  always_comb begin
    logic [7:0] st_vec;
    st_vec = 8'h00;
    for (int i = 0; i < 4; i++) begin
      st_vec[2*i +: 2] = bk_st[i];
    end
    nxt_mode = mode_ff;
    nxt_wcnt = wcnt_ff + {15'h0, mem_we};
    nxt_rdata = 32'h0000_0000;
    if (reg_wr_i && reg_addr_i == `SDWP_REG_MODE) begin
      nxt_mode = reg_wdata_i[9:0] & `SDWP_MODE_MASK;
    end
    if (reg_rd_i) begin
      case (reg_addr_i)
        `SDWP_REG_MODE: nxt_rdata = {22'h0, mode_ff};
        `SDWP_REG_STATUS: begin
          nxt_rdata = {24'h000000, st_vec};
          nxt_rdata[`SDWP_ST_WR_BIT] = wr_act_ff;
          nxt_rdata[`SDWP_ST_RD_BIT] = rd_act_ff;
        end
        `SDWP_REG_WCOUNT: nxt_rdata = {16'h0000, wcnt_ff};
        default: nxt_rdata = 32'h0000_0000;
      endcase
    end
  end

  // Register file and output flops; data pins stay high-Z
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mode_ff <= `SDWP_MODE_RST;
      wcnt_ff <= 16'h0000;
      rdata_ff <= 32'h0000_0000;
    end else begin
      mode_ff <= nxt_mode;
      wcnt_ff <= nxt_wcnt;
      rdata_ff <= nxt_rdata;
    end
  end
  assign reg_rdata_o = rdata_ff;
  assign wr_busy_o = wr_act_ff;
  assign dq_o = 16'h0000;
  assign dq_oe_o = 1'b0;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  property p_first_cap;
    wr_go && !dqm_i |-> mem_we && mem_addr == {ba, col}
      ##1 wcnt_ff == $past(wcnt_ff) + 16'h0001;
  endproperty
  a_first_cap: assert property (p_first_cap)
    else $error("write data not captured on command edge");

  property p_idle_drop;
    !wr_act_ff && !wr_go |-> !mem_we && !dq_oe_o;
  endproperty
  a_idle_drop: assert property (p_idle_drop)
    else $error("data stored outside a burst");

  property p_page_wrap;
    wr_act_ff && wr_cont_ff && wr_col_ff == 8'hFF && cmd == CMD_NOP
      |=> wr_act_ff && wr_col_ff == 8'h00;
  endproperty
  a_page_wrap: assert property (p_page_wrap)
    else $error("continuous burst did not wrap to column 0");

  property p_new_owner;
    wr_go |=> wr_bank_ff == $past(ba) && wr_cont_ff == $past(cont);
  endproperty
  a_new_owner: assert property (p_new_owner)
    else $error("new write did not take over the burst");

  property p_read_cut;
    rd_go |-> !mem_we ##1 !wr_act_ff ##1 (cmd != CMD_NOP || !mem_we);
  endproperty
  a_read_cut: assert property (p_read_cut)
    else $error("write continued after read");

  property p_bst_drop;
    cmd == CMD_BST |-> !mem_we ##1 !wr_act_ff;
  endproperty
  a_bst_drop: assert property (p_bst_drop)
    else $error("data stored on terminate edge");

  property p_single;
    wr_go && mode_ff[`SDWP_WBM_BIT] && !cont |=> !wr_act_ff;
  endproperty
  a_single: assert property (p_single)
    else $error("single-write mode wrote more than one column");

  property p_all_pre;
    cmd == CMD_PRE && scope |=> bk_st[0] != BANK_ACTIVE
      && bk_st[1] != BANK_ACTIVE && bk_st[2] != BANK_ACTIVE
      && bk_st[3] != BANK_ACTIVE;
  endproperty
  a_all_pre: assert property (p_all_pre)
    else $error("all-bank precharge left a bank open");

  property p_no_cont_ap;
    wr_go && cont |=> !wr_ap_ff && wr_act_ff;
  endproperty
  a_no_cont_ap: assert property (p_no_cont_ap)
    else $error("auto precharge armed in continuous mode");

  property p_cut_sched;
    wr_go && wr_act_ff && wr_ap_ff && wr_bank_ff != ba
      |-> bk_sched[wr_bank_ff];
  endproperty
  a_cut_sched: assert property (p_cut_sched)
    else $error("interrupted auto write not scheduled");
endmodule
`default_nettype wire

// ---- dv/sdwp_ctrl_model.sv ----
// Memory controller model driving commands, mask and write data
`timescale 1ns/1ns
`default_nettype none
module sdwp_ctrl_model #(
  parameter int ACT_GAP = 1,
  parameter int TRP_GAP = 2
) (
  // Clock
  input wire logic clk_i,
  // Command and address pins
  output logic cs_n_o,
  output logic ras_n_o,
  output logic cas_n_o,
  output logic we_n_o,
  output logic [11:0] addr_o,
  output logic bank_select_low_o,
  output logic bank_select_high_o,
  // Data pins
  output logic dqm_o,
  output sdwp_pkg::sdwp_word_t dq_o
);
  import sdwp_pkg::*;
  localparam logic [3:0] CODE_ACT = 4'h3;
  localparam logic [3:0] CODE_PRE = 4'h2;
  localparam logic [3:0] CODE_NOP = 4'h7;
  // Last data, released flag and toggle for a free data bus
  sdwp_word_t dq_ff;
  logic rel_ff;
  logic tgl_ff;
  initial begin
    {cs_n_o, ras_n_o, cas_n_o, we_n_o} = CODE_NOP;
    addr_o = 12'h000;
    {bank_select_high_o, bank_select_low_o} = 2'h0;
    dqm_o = 1'b0;
    dq_ff = 16'h0000;
    rel_ff = 1'b1;
    tgl_ff = 1'b0;
  end
  // A released data bus changes every cycle
  always @(posedge clk_i) begin
    tgl_ff <= ~tgl_ff;
  end
  assign dq_o = rel_ff ? (dq_ff ^ {16{tgl_ff}}) : dq_ff;
  // One command, applied just after an edge, held until the next call
  task automatic drive(input logic [3:0] c, input logic [1:0] b,
      input logic [11:0] a, input logic m, input sdwp_word_t d,
      input logic rel);
    @(posedge clk_i);
    {cs_n_o, ras_n_o, cas_n_o, we_n_o} <= c;
    {bank_select_high_o, bank_select_low_o} <= b;
    addr_o <= a;
    dqm_o <= m;
    dq_ff <= d;
    rel_ff <= rel;
  endtask
  // Idle cycles with the data bus released; don't-care pins wander
  task automatic nop(input int n);
    repeat (n) begin
      drive($urandom_range(0, 1) ? {1'b1, 3'($urandom)} : CODE_NOP,
        2'($urandom), 12'($urandom), 1'($urandom), dq_ff, 1'b1);
    end
  endtask
  task automatic act(input logic [1:0] b);
    drive(CODE_ACT, b, 12'h000, 1'b0, dq_ff, 1'b1);
    nop(ACT_GAP);
  endtask
  task automatic pre(input logic [1:0] b, input logic all);
    drive(CODE_PRE, b, {1'b0, all, 10'h000}, 1'b1, dq_ff, 1'b1);
    nop(TRP_GAP);
  endtask
endmodule
`default_nettype wire

// ---- dv/testbench.sv ----
// Self-checking bench for the write and precharge block
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import sdwp_pkg::*;
  localparam logic [3:0] C_WR = 4'h4;
  localparam logic [3:0] C_RD = 4'h5;
  localparam logic [3:0] C_BST = 4'h6;
  localparam logic [3:0] C_NOP = 4'h7;
  // Clock, reset and pins
  logic clk_i, rst_n_i, cs_n, ras_n, cas_n, we_n, bsl, bsh, dqm;
  logic [11:0] addr;
  sdwp_word_t dq_in, dq_o;
  logic dq_oe_o, wr_busy_o, reg_wr, reg_rd;
  logic [3:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata_o, ecnt, rdv;
  logic [1:0] est [4];
  int n_errors, num_checks, n;
  logic [7:0] m;
  sdwp_top dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .cs_n_i(cs_n),
    .ras_n_i(ras_n), .cas_n_i(cas_n), .we_n_i(we_n), .addr_i(addr),
    .bank_select_low_i(bsl), .bank_select_high_i(bsh), .dqm_i(dqm),
    .dq_i(dq_in), .dq_o(dq_o), .dq_oe_o(dq_oe_o), .reg_addr_i(reg_addr),
    .reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd),
    .reg_rdata_o(reg_rdata_o), .wr_busy_o(wr_busy_o));
  sdwp_ctrl_model u_ctl (.clk_i(clk_i), .cs_n_o(cs_n), .ras_n_o(ras_n),
    .cas_n_o(cas_n), .we_n_o(we_n), .addr_o(addr),
    .bank_select_low_o(bsl), .bank_select_high_o(bsh), .dqm_o(dqm),
    .dq_o(dq_in));
  // Clock of 50 ns period
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  // Compare and count
  task automatic check(input string nm, input logic [31:0] seen,
      input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Verdict and end of run
  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // Register write, one strobe cycle
  task automatic reg_w(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_i);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_i);
    reg_wr <= 1'b0;
  endtask
  // Register read, data taken in the cycle after the strobe
  task automatic chk_rd(input string nm, input logic [3:0] a,
      input logic [31:0] exp);
    @(posedge clk_i);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_i);
    reg_rd <= 1'b0;
    #1;
    rdv = reg_rdata_o;
    check(nm, rdv, exp);
  endtask
  // Expected status word from the bank states
  function automatic logic [31:0] stw();
    return {24'h0, est[3], est[2], est[1], est[0]};
  endfunction
  // Elements stored from a burst cut after n edges
  function automatic logic [31:0] stored(int n, int len, logic [7:0] mk);
    logic [31:0] c;
    c = 0;
    for (int i = 0; i < n && i < len; i++) begin
      if (!mk[i % 8]) c++;
    end
    return c;
  endfunction
  // Data edges after a command, mask per edge
  task automatic dnop(input int k, input logic [7:0] mk);
    for (int i = 0; i < k; i++) begin
      u_ctl.drive(C_NOP, 2'h0, 12'h000, mk[i % 8], 16'($urandom), 1'b0);
    end
  endtask
  // WRITE followed by k-1 data edges
  task automatic wseq(input logic [1:0] b, input logic [11:0] a,
      input int k, input logic [7:0] mk);
    u_ctl.drive(C_WR, b, a, mk[0], 16'($urandom), 1'b0);
    dnop(k - 1, {mk[0], mk[7:1]});
  endtask
  // Watchdog
  initial begin
    repeat (20000) @(posedge clk_i);
    n_errors++;
    summarize();
  end
  initial begin
    rst_n_i = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 32'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    ecnt = 32'h0;
    est = '{2'h0, 2'h0, 2'h0, 2'h0};
    n = $urandom(58);
    repeat (6) @(posedge clk_i);
    rst_n_i <= 1'b1;
    chk_rd("mode", 4'h0, 32'h023);
    chk_rd("status", 4'h4, 32'h0);
    chk_rd("wcount", 4'h8, 32'h0);
    reg_w(4'hC, 32'hFFFF);
    chk_rd("unmapped", 4'hC, 32'h0);
    n = $urandom;
    m = 8'($urandom);
    reg_w(4'h0, 32'(n));
    chk_rd("mode_rand", 4'h0, 32'(n) & 32'h277);
    reg_w({m[3:2], m[1:0] | 2'h1}, 32'($urandom));
    chk_rd("unmapped_rand", {m[3:2], m[1:0] | 2'h1}, 32'h0);
    chk_rd("mode_keep", 4'h0, 32'(n) & 32'h277);
    reg_w(4'h0, 32'hFFF);
    chk_rd("mode_mask", 4'h0, 32'h277);
    $display("test reset done");
    for (int b = 0; b < 4; b++) begin
      u_ctl.act(2'(b));
      est[b] = 2'h1;
    end
    chk_rd("status_act", 4'h4, stw());
    for (int k = 0; k < 4; k++) begin
      reg_w(4'h0, 32'(k));
      wseq(2'h1, 12'h000, 9, 8'h00);
      u_ctl.nop(2);
      ecnt += 32'(1 << k);
      chk_rd("wcount_bl", 4'h8, ecnt);
    end
    reg_w(4'h0, 32'h002);
    wseq(2'h1, 12'h000, 2, 8'h00);
    #1 check("busy_mid", {31'h0, wr_busy_o}, 32'h1);
    dnop(5, 8'h00);
    u_ctl.nop(2);
    ecnt += 4;
    #1 check("busy_end", {31'h0, wr_busy_o}, 32'h0);
    check("dq_drive", {15'h0, dq_oe_o, dq_o}, 32'h0);
    chk_rd("wcount_bl4", 4'h8, ecnt);
    $display("test burst lengths done");
    reg_w(4'h0, 32'h003);
    for (int k = 0; k < 3; k++) begin
      wseq(2'h1, 12'h000, 3, 8'h00);
      if (k == 0) wseq(2'h2, 12'h010, 8, 8'h00);
      else u_ctl.drive(k == 1 ? C_RD : C_BST, 2'h1, 12'h000, 1'b0,
        16'hA5A5, 1'b0);
      dnop(3, 8'h00);
      u_ctl.nop(2);
      ecnt += (k == 0) ? 11 : 3;
      chk_rd("wcount_trunc", 4'h8, ecnt);
    end
    for (int k = 0; k < 6; k++) begin
      n = 1 + $urandom % 10;
      m = 8'($urandom);
      wseq(2'($urandom), 12'(8 * $urandom_range(0, 31)), n, m);
      u_ctl.drive(C_BST, 2'h0, 12'h000, 1'b0, 16'h5A5A, 1'b0);
      u_ctl.nop(2);
      ecnt += stored(n, 8, m);
      chk_rd("wcount_rand", 4'h8, ecnt);
    end
    $display("test truncation done");
    reg_w(4'h0, 32'h203);
    wseq(2'h0, 12'h000, 6, 8'h00);
    u_ctl.nop(2);
    ecnt += 1;
    chk_rd("wcount_single", 4'h8, ecnt);
    for (int k = 0; k < 2; k++) begin
      reg_w(4'h0, k == 0 ? 32'h207 : 32'h007);
      wseq(2'h3, 12'h4FA, 12, 8'h00);
      u_ctl.drive(C_BST, 2'h3, 12'h000, 1'b0, 16'h0, 1'b0);
      u_ctl.nop(4);
      ecnt += 12;
      chk_rd("wcount_cont", 4'h8, ecnt);
      chk_rd("status_cont", 4'h4, stw());
    end
    $display("test single and continuous done");
    reg_w(4'h0, 32'h002);
    wseq(2'h1, 12'h400, 4, 8'h00);
    chk_rd("status_rec", 4'h4, stw());
    u_ctl.nop(3);
    ecnt += 4;
    est[1] = 2'h0;
    chk_rd("status_auto", 4'h4, stw());
    for (int k = 0; k < 4; k++) begin
      u_ctl.act(2'h1);
      if (k[0]) begin
        u_ctl.drive(C_RD, 2'h1, 12'h400, k[1], 16'h0, 1'b1);
        u_ctl.drive(C_NOP, 2'h0, 12'h000, k[1], 16'h0, 1'b1);
      end else begin
        wseq(2'h1, 12'h400, 2, 8'h00);
      end
      if (k[1]) wseq(2'h2, 12'h000, 4, 8'h00);
      else u_ctl.drive(C_RD, 2'h2, 12'h000, 1'b0, 16'h0, 1'b1);
      u_ctl.nop(6);
      ecnt += (k[0] ? 0 : 2) + (k[1] ? 4 : 0);
      chk_rd("wcount_intr", 4'h8, ecnt);
      chk_rd("status_intr", 4'h4, stw());
    end
    $display("test auto precharge done");
    wseq(2'h3, 12'h000, 2, 8'h00);
    u_ctl.drive(C_NOP, 2'h0, 12'h000, 1'b1, 16'h0, 1'b0);
    u_ctl.pre(2'h3, 1'b0);
    ecnt += 2;
    est[3] = 2'h0;
    chk_rd("status_pre", 4'h4, stw());
    chk_rd("wcount_pre", 4'h8, ecnt);
    u_ctl.pre(2'h1, 1'b1);
    est = '{2'h0, 2'h0, 2'h0, 2'h0};
    chk_rd("status_all", 4'h4, stw());
    wseq(2'h0, 12'h000, 4, 8'h00);
    u_ctl.nop(2);
    chk_rd("wcount_idle", 4'h8, ecnt);
    $display("test precharge done");
    summarize();
  end
endmodule
`default_nettype wire
